// ==== design/bank_track.sv ====
// Purpose: State of one SDRAM bank
// Assumes: Commands arrive already decoded and accepted
// Notes:   Precharge-all does not restart a precharge or a recovery
`timescale 1ns/1ps
module bank_track (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire sdram_bank_pkg::bankCmd_t  cmd,
   output sdram_bank_pkg::bankState_t     bankState
);
   import sdram_bank_pkg::*;

   typedef struct packed {
      bankState_t       st;
      logic [CNT_W-1:0] cnt;
   } track_t;

   track_t track_reg;
   track_t track_next;
   logic   cntDone;

   function automatic bankState_t accessState(input bankCmd_t c);
      if (c.wr) begin
         return c.autoPre ? B_WRITE_AP : B_WRITE;
      end
      return c.autoPre ? B_READ_AP : B_READ;
   endfunction : accessState

   assign cntDone   = (track_reg.cnt == '0);
   assign bankState = track_reg.st;

   // ***************************************
   // Next state
   // ***************************************
   always_comb begin
      track_next = track_reg;
      if (!cntDone) begin
         track_next.cnt = track_reg.cnt - 1'b1;
      end
      case (track_reg.st)
         B_IDLE: begin
            if (cmd.act) begin
               track_next.st  = B_ACTIVATING;
               track_next.cnt = ACT_CYC - 1'b1;
            end
         end
         B_ACTIVATING: begin
            if (cntDone) begin
               track_next.st = B_ACTIVE;
            end
         end
         B_ACTIVE, B_READ, B_WRITE: begin
            if (cmd.rd | cmd.wr) begin
               track_next.st = accessState(cmd);
            end else if (cmd.pre) begin
               track_next.st  = B_PRECHARGING;
               track_next.cnt = PRECHARGE_CYC - 1'b1;
            end else if (track_reg.st != B_ACTIVE && (cmd.burstEnd | cmd.otherAccess)) begin
               track_next.st = B_ACTIVE;
            end
         end
         B_READ_AP: begin
            if (cmd.burstEnd | cmd.otherAccess) begin
               track_next.st  = B_PRECHARGING;
               track_next.cnt = PRECHARGE_CYC - 1'b1;
            end
         end
         B_WRITE_AP: begin
            if (cmd.burstEnd | cmd.otherAccess) begin
               track_next.st  = B_RECOVER;
               track_next.cnt = WR_RECOV_CYC - 1'b1;
            end
         end
         B_RECOVER: begin
            if (cntDone) begin
               track_next.st  = B_PRECHARGING;
               track_next.cnt = PRECHARGE_CYC - 1'b1;
            end
         end
         B_PRECHARGING: begin
            if (cntDone) begin
               track_next.st = B_IDLE;
            end
         end
         default: begin
            track_next.st  = B_IDLE;
            track_next.cnt = '0;
         end
      endcase
      if (cmd.preAll && !(track_reg.st inside {B_IDLE, B_PRECHARGING, B_RECOVER})) begin
         track_next.st  = B_PRECHARGING;
         track_next.cnt = PRECHARGE_CYC - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         track_reg <= '{st: B_IDLE, cnt: '0};
      end else begin
         track_reg <= track_next;
      end
   end

   // ***************************************
   // Checks
   // ***************************************
   property p_pre_len;
      @(posedge clk) disable iff (sys_rst)
      (track_reg.st == B_IDLE && $past(track_reg.st) == B_PRECHARGING)
         |-> $past(track_reg.st, PRECHARGE_CYC) == B_PRECHARGING
             && $past(track_reg.st, PRECHARGE_CYC + 1) != B_PRECHARGING;
   endproperty
   a_pre_len: assert property (p_pre_len) else $error("Precharge length wrong");

   property p_recover_len;
      @(posedge clk) disable iff (sys_rst)
      (track_reg.st == B_PRECHARGING && $past(track_reg.st) == B_RECOVER && !$past(cmd.preAll))
         |-> $past(track_reg.st, WR_RECOV_CYC) == B_RECOVER
             && $past(track_reg.st, WR_RECOV_CYC + 1) != B_RECOVER;
   endproperty
   a_recover_len: assert property (p_recover_len) else $error("Write recovery length wrong");

endmodule : bank_track

// ==== design/sdram_bank_interleave.sv ====
// Purpose: Bank interleave tracker of a four-bank SDRAM
// Assumes: Command pins on the same clock as this block
// Notes:   Data beat flags only; no data storage
`timescale 1ns/1ps
module sdram_bank_interleave #(
   parameter int BURST_LEN = 4,
   parameter int READ_LAT  = 3
) (
   input  wire logic                                 clk,
   input  wire logic                                 sys_rst,
   input  wire logic                                 cke,
   input  wire sdram_bank_pkg::cmdPins_t             cmdPins,
   output sdram_bank_pkg::bankState_t   [3:0]        bankStates,
   output sdram_bank_pkg::globalState_t              globalState,
   output sdram_bank_pkg::dataStat_t                 dataStat,
   output logic                                      cmdIgnored
);
   import sdram_bank_pkg::*;

   localparam int LEN_W = $clog2(BURST_LEN + 1);

   if (!(BURST_LEN inside {2, 4, 8}) || !(READ_LAT inside {2, 3})) begin : g_check
      $error("Unsupported burst length or read latency");
   end

   typedef struct packed {
      globalState_t                gs;
      logic [CNT_W-1:0]            gCnt;
      logic                        ckePrev;
      logic [READ_LAT-1:0]         pipeV;
      logic [READ_LAT-1:0][1:0]    pipeB;
      logic [LEN_W-1:0]            rdLeft;
      logic [LEN_W-1:0]            wrLeft;
      dataStat_t                   ds;
      logic                        lastWr;
      logic [1:0]                  lastBank;
      logic                        ignored;
   } state_t;

   state_t     state_reg;
   state_t     state_next;
   logic       isAct;
   logic       isRd;
   logic       isWr;
   logic       isPre;
   logic       isRef;
   logic       isMode;
   logic       isBst;
   logic       isExec;
   logic       ckeOk;
   logic       cmdOpen;
   logic       allIdle;
   logic [3:0] idleVec;
   logic       actAcc;
   logic       rdAcc;
   logic       wrAcc;
   logic       preAcc;
   logic       preAllAcc;
   logic       refAcc;
   logic       modeAcc;
   logic       bstAcc;
   logic       srEnter;
   logic       endRd;
   logic       endWr;
   logic       flushRd;
   logic [3:0] sinceFlush;

   // ***************************************
   // Command decode
   // ***************************************
   assign isAct  = ~cmdPins.csN & ~cmdPins.rasN &  cmdPins.casN &  cmdPins.weN;
   assign isRd   = ~cmdPins.csN &  cmdPins.rasN & ~cmdPins.casN &  cmdPins.weN;
   assign isWr   = ~cmdPins.csN &  cmdPins.rasN & ~cmdPins.casN & ~cmdPins.weN;
   assign isPre  = ~cmdPins.csN & ~cmdPins.rasN &  cmdPins.casN & ~cmdPins.weN;
   assign isRef  = ~cmdPins.csN & ~cmdPins.rasN & ~cmdPins.casN &  cmdPins.weN;
   assign isMode = ~cmdPins.csN & ~cmdPins.rasN & ~cmdPins.casN & ~cmdPins.weN;
   assign isBst  = ~cmdPins.csN &  cmdPins.rasN &  cmdPins.casN & ~cmdPins.weN;
   assign isExec = ~cmdPins.csN & ~(cmdPins.rasN & cmdPins.casN & cmdPins.weN);

   assign ckeOk   = state_reg.ckePrev & cke;
   assign cmdOpen = ckeOk & (state_reg.gs == G_NORMAL);
   assign allIdle = &idleVec;

   // Other banks never gate a bank command
   assign actAcc    = cmdOpen & isAct;
   assign rdAcc     = cmdOpen & isRd;
   assign wrAcc     = cmdOpen & isWr;
   assign preAcc    = cmdOpen & isPre & ~cmdPins.a10;
   assign preAllAcc = cmdOpen & isPre & cmdPins.a10;
   assign refAcc    = cmdOpen & isRef & allIdle;
   assign modeAcc   = cmdOpen & isMode & allIdle;
   assign bstAcc    = cmdOpen & isBst;
   assign srEnter   = state_reg.ckePrev & ~cke & isRef & allIdle & (state_reg.gs == G_NORMAL);

   // Natural burst ends; a queued read keeps its bank busy
   assign endRd   = (state_reg.rdLeft == LEN_W'(1)) & ~(|state_reg.pipeV);
   assign endWr   = (state_reg.wrLeft == LEN_W'(1));
   assign flushRd = wrAcc | (bstAcc & ~state_reg.lastWr);

   // ***************************************
   // Banks
   // ***************************************
   for (genvar b = 0; b < 4; b++) begin : g_bank
      bankCmd_t bc;
      logic     hit;
      assign hit            = (cmdPins.bank == 2'(b));
      assign bc.act         = actAcc & hit;
      assign bc.rd          = rdAcc & hit;
      assign bc.wr          = wrAcc & hit;
      assign bc.pre         = preAcc & hit;
      assign bc.autoPre     = cmdPins.a10;
      assign bc.otherAccess = (rdAcc | wrAcc) & ~hit;
      assign bc.burstEnd    = (endRd & (state_reg.ds.rdBank == 2'(b)))
                            | (endWr & (state_reg.ds.wrBank == 2'(b)))
                            | (bstAcc & (state_reg.lastBank == 2'(b)));
      assign bc.preAll      = preAllAcc;
      assign idleVec[b]     = (bankStates[b] == B_IDLE);

      bank_track u_bank (
         .clk       (clk),
         .sys_rst   (sys_rst),
         .cmd       (bc),
         .bankState (bankStates[b])
      );
   end

   // ***************************************
   // Global state and bursts
   // ***************************************
   always_comb begin
      state_next         = state_reg;
      state_next.ckePrev = cke;
      state_next.ignored = isExec & ~(actAcc | rdAcc | wrAcc | preAcc | preAllAcc
                                    | refAcc | modeAcc | bstAcc | srEnter);
      if (state_reg.gCnt != '0) begin
         state_next.gCnt = state_reg.gCnt - 1'b1;
      end
      case (state_reg.gs)
         G_NORMAL: begin
            if (refAcc) begin
               state_next.gs   = G_REFRESH;
               state_next.gCnt = REFRESH_CYC - 1'b1;
            end else if (modeAcc) begin
               state_next.gs   = G_MODE;
               state_next.gCnt = MODE_LOAD_CYC - 1'b1;
            end else if (preAllAcc) begin
               state_next.gs   = G_PREALL;
               state_next.gCnt = PRECHARGE_CYC - 1'b1;
            end else if (srEnter) begin
               state_next.gs = G_SELF;
            end
         end
         G_REFRESH, G_MODE, G_PREALL: begin
            if (state_reg.gCnt == '0) begin
               state_next.gs = G_NORMAL;
            end
         end
         G_SELF: begin
            if (cke) begin
               state_next.gs   = G_EXIT;
               state_next.gCnt = SR_EXIT_CYC - 1'b1;
            end
         end
         G_EXIT: begin
            if (state_reg.gCnt == '0) begin
               state_next.gs = G_NORMAL;
            end
         end
         default: begin
            state_next.gs   = G_NORMAL;
            state_next.gCnt = '0;
         end
      endcase

      // Read data: a newer read replaces the old one on arrival
      state_next.pipeV = {state_reg.pipeV[READ_LAT-2:0], rdAcc};
      state_next.pipeB = {state_reg.pipeB[READ_LAT-2:0], cmdPins.bank};
      if (state_reg.pipeV[READ_LAT-1]) begin
         state_next.rdLeft    = LEN_W'(BURST_LEN);
         state_next.ds.rdBank = state_reg.pipeB[READ_LAT-1];
      end else if (state_reg.rdLeft != '0) begin
         state_next.rdLeft = state_reg.rdLeft - 1'b1;
      end
      if (flushRd) begin
         state_next.pipeV  = '0;
         state_next.rdLeft = '0;
      end
      state_next.ds.rdValid = (state_next.rdLeft != '0);

      // Write data: first datum taken with the command
      if (wrAcc) begin
         state_next.wrLeft    = LEN_W'(BURST_LEN - 1);
         state_next.ds.wrBank = cmdPins.bank;
      end else if (rdAcc | (bstAcc & state_reg.lastWr)) begin
         state_next.wrLeft = '0;
      end else if (state_reg.wrLeft != '0) begin
         state_next.wrLeft = state_reg.wrLeft - 1'b1;
      end
      state_next.ds.wrAccept = wrAcc | ((state_reg.wrLeft != '0) & ~rdAcc & ~(bstAcc & state_reg.lastWr));

      if (rdAcc | wrAcc) begin
         state_next.lastWr   = wrAcc;
         state_next.lastBank = cmdPins.bank;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg         <= '0;
         state_reg.gs      <= G_NORMAL;
      end else begin
         state_reg <= state_next;
      end
   end

   assign globalState = state_reg.gs;
   assign dataStat    = state_reg.ds;
   assign cmdIgnored  = state_reg.ignored;

   // ***************************************
   // Checks
   // ***************************************
   always_ff @(posedge clk) begin
      if (sys_rst || flushRd) begin
         sinceFlush <= 4'h0;
      end else if (sinceFlush != 4'hf) begin
         sinceFlush <= sinceFlush + 4'h1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_refresh_len;
      (state_reg.gs == G_NORMAL && $past(state_reg.gs) == G_REFRESH)
         |-> $past(state_reg.gs, REFRESH_CYC) == G_REFRESH
             && $past(state_reg.gs, REFRESH_CYC + 1) != G_REFRESH && allIdle;
   endproperty
   a_refresh_len: assert property (p_refresh_len) else $error("Refresh length wrong");

   property p_mode_len;
      (state_reg.gs == G_NORMAL && $past(state_reg.gs) == G_MODE)
         |-> $past(state_reg.gs, MODE_LOAD_CYC) == G_MODE
             && $past(state_reg.gs, MODE_LOAD_CYC + 1) != G_MODE;
   endproperty
   a_mode_len: assert property (p_mode_len) else $error("Mode load length wrong");

   property p_preall_len;
      (state_reg.gs == G_NORMAL && $past(state_reg.gs) == G_PREALL)
         |-> $past(state_reg.gs, PRECHARGE_CYC) == G_PREALL
             && $past(state_reg.gs, PRECHARGE_CYC + 1) != G_PREALL;
   endproperty
   a_preall_len: assert property (p_preall_len) else $error("Precharge-all length wrong");

   property p_pre_idle;
      (preAcc && bankStates[cmdPins.bank] == B_IDLE)
         |=> bankStates[$past(cmdPins.bank)] == B_IDLE;
   endproperty
   a_pre_idle: assert property (p_pre_idle) else $error("Precharge changed idle bank");

   property p_rap_cut;
      ((rdAcc || wrAcc) && bankStates[state_reg.lastBank] == B_READ_AP
         && cmdPins.bank != state_reg.lastBank)
         |=> bankStates[$past(state_reg.lastBank)] == B_PRECHARGING;
   endproperty
   a_rap_cut: assert property (p_rap_cut) else $error("Read auto-precharge not started");

   property p_wap_cut;
      ((rdAcc || wrAcc) && bankStates[state_reg.lastBank] == B_WRITE_AP
         && cmdPins.bank != state_reg.lastBank)
         |=> bankStates[$past(state_reg.lastBank)] == B_RECOVER;
   endproperty
   a_wap_cut: assert property (p_wap_cut) else $error("Write recovery not started");

   property p_rd_lat;
      ($past(rdAcc, READ_LAT + 1) && sinceFlush > READ_LAT)
         |-> state_reg.ds.rdValid && state_reg.ds.rdBank == $past(cmdPins.bank, READ_LAT + 1);
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("Read data latency wrong");

   property p_wr_cuts_rd;
      wrAcc |=> !state_reg.ds.rdValid && state_reg.pipeV == '0;
   endproperty
   a_wr_cuts_rd: assert property (p_wr_cuts_rd) else $error("Write did not cut read");

   property p_rd_cuts_wr;
      rdAcc |=> !state_reg.ds.wrAccept ##1 !state_reg.ds.wrAccept || $past(wrAcc);
   endproperty
   a_rd_cuts_wr: assert property (p_rd_cuts_wr) else $error("Read did not cut write");

   property p_wr_start;
      wrAcc |=> state_reg.ds.wrAccept && state_reg.ds.wrBank == $past(cmdPins.bank)
                && state_reg.wrLeft == BURST_LEN - 1;
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("Write burst start wrong");

   property p_cke_gate;
      (isRd && (!cke || !state_reg.ckePrev)) |=> !state_reg.pipeV[0];
   endproperty
   a_cke_gate: assert property (p_cke_gate) else $error("Read taken without clock enable");

   property p_bst_rd;
      (bstAcc && !state_reg.lastWr) |=> !state_reg.ds.rdValid;
   endproperty
   a_bst_rd: assert property (p_bst_rd) else $error("Burst terminate missed read");

   property p_pre_other;
      (preAcc && cmdPins.bank != state_reg.ds.rdBank && state_reg.rdLeft > 1
         && !state_reg.pipeV[READ_LAT-1])
         |=> state_reg.rdLeft == $past(state_reg.rdLeft) - 1;
   endproperty
   a_pre_other: assert property (p_pre_other) else $error("Precharge disturbed burst");

   c_refresh: cover property (refAcc ##1 state_reg.gs == G_REFRESH);
   c_rd_rd:   cover property (rdAcc ##1 rdAcc);
   c_rap_cut: cover property (rdAcc && bankStates[state_reg.lastBank] == B_READ_AP
                              && cmdPins.bank != state_reg.lastBank);
   c_selfref: cover property (state_reg.gs == G_EXIT ##1 state_reg.gs == G_NORMAL);

endmodule : sdram_bank_interleave

// ==== include/sdram_bank_pkg.sv ====
// Purpose: Shared types and timing for the SDRAM bank state tracker
// Assumes: 100 MHz clock shared with the memory controller
// Notes:   Timing figures are plain defaults, rounded up to whole cycles
package sdram_bank_pkg;

   localparam int CLK_PERIOD_NS               = 10;
   localparam int PRECHARGE_TIME_NS           = 20;
   localparam int MODE_LOAD_DELAY_NS          = 20;
   localparam int WRITE_RECOVERY_TIME_NS      = 15;
   localparam int SELF_REFRESH_EXIT_TIME_NS   = 70;
   localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 20;
   localparam int REFRESH_CYCLE_TIME_NS       = 70;
   localparam int CNT_W                       = 4;

   // Least time in ns to whole cycles, never below one
   function automatic logic [CNT_W-1:0] toCycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (c < 1) begin
         c = 1;
      end
      return CNT_W'(c);
   endfunction : toCycles

   localparam logic [CNT_W-1:0] PRECHARGE_CYC = toCycles(PRECHARGE_TIME_NS);
   localparam logic [CNT_W-1:0] MODE_LOAD_CYC = toCycles(MODE_LOAD_DELAY_NS);
   localparam logic [CNT_W-1:0] WR_RECOV_CYC  = toCycles(WRITE_RECOVERY_TIME_NS);
   localparam logic [CNT_W-1:0] SR_EXIT_CYC   = toCycles(SELF_REFRESH_EXIT_TIME_NS);
   localparam logic [CNT_W-1:0] ACT_CYC       = toCycles(ACTIVATE_TO_ACCESS_DELAY_NS);
   localparam logic [CNT_W-1:0] REFRESH_CYC   = toCycles(REFRESH_CYCLE_TIME_NS);

   typedef enum logic [8:0] {
      B_IDLE        = 9'h001,
      B_ACTIVATING  = 9'h002,
      B_ACTIVE      = 9'h004,
      B_READ        = 9'h008,
      B_WRITE       = 9'h010,
      B_READ_AP     = 9'h020,
      B_WRITE_AP    = 9'h040,
      B_RECOVER     = 9'h080,
      B_PRECHARGING = 9'h100
   } bankState_t;

   typedef enum logic [5:0] {
      G_NORMAL  = 6'h01,
      G_REFRESH = 6'h02,
      G_MODE    = 6'h04,
      G_PREALL  = 6'h08,
      G_SELF    = 6'h10,
      G_EXIT    = 6'h20
   } globalState_t;

   typedef struct packed {
      logic       csN;
      logic       rasN;
      logic       casN;
      logic       weN;
      logic [1:0] bank;
      logic       a10;
   } cmdPins_t;

   typedef struct packed {
      logic act;
      logic rd;
      logic wr;
      logic pre;
      logic autoPre;
      logic otherAccess;
      logic burstEnd;
      logic preAll;
   } bankCmd_t;

   typedef struct packed {
      logic       rdValid;
      logic [1:0] rdBank;
      logic       wrAccept;
      logic [1:0] wrBank;
   } dataStat_t;

endpackage : sdram_bank_pkg

// ==== test/ctrl_model.sv ====
// Purpose: Memory controller side of the command pins
// Assumes: Bench supplies wanted commands at the falling edge
// Notes:   Busy global state turns every request into a no-op
`timescale 1ns/1ps
module ctrl_model (
   input  wire sdram_bank_pkg::cmdPins_t     req,
   input  wire sdram_bank_pkg::globalState_t globalState,
   output sdram_bank_pkg::cmdPins_t          cmdPins
);
   import sdram_bank_pkg::*;
   // ****************************************
   // Command gate
   // ****************************************
   // No-op while refresh, mode load, precharge-all, self refresh or self refresh exit runs
   assign cmdPins = (globalState == G_NORMAL) ? req : cmdPins_t'(7'h38);
endmodule : ctrl_model

// ==== test/sdram_bank_interleave_test.sv ====
// Purpose: Self-checking bench of the bank interleave tracker
// Assumes: Burst length 4, read latency 3
// Notes:   Expected bank states kept in a small model array
`timescale 1ns/1ps
module sdram_bank_interleave_test;
   import sdram_bank_pkg::*;
   logic             clk = 0;
   logic             sys_rst = 1;
   logic             cke = 1;
   cmdPins_t         req;
   cmdPins_t         pins;
   bankState_t [3:0] bankStates;
   globalState_t     globalState;
   dataStat_t        dataStat;
   logic             cmdIgnored;
   int               err_total = 0;
   int               checks = 0;
   int               cyc = 0;
   int               seed = 32'h81be76c7;
   logic [1:0]       b;
   bankState_t       expSt [4];
   // ****************************************
   // Clock, design and controller
   // ****************************************
   always #5 clk = ~clk;
   sdram_bank_interleave #(.BURST_LEN(4), .READ_LAT(3)) dut (.clk(clk), .sys_rst(sys_rst), .cke(cke),
      .cmdPins(pins), .bankStates(bankStates), .globalState(globalState), .dataStat(dataStat),
      .cmdIgnored(cmdIgnored));
   ctrl_model ctl (.req(req), .globalState(globalState), .cmdPins(pins));
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic cmd(input logic [3:0] s, input logic [1:0] bk, input logic a);
      @(negedge clk) req = {s, bk, a};
      @(negedge clk) req = 7'h38;
   endtask : cmd
   task automatic banks;
      for (int i = 0; i < 4; i++) begin
         chk(bankStates[i], expSt[i]);
      end
   endtask : banks
   task automatic conclude;
      if (err_total == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         conclude();
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      req = 7'h38;
      tick(12);
      sys_rst = 0;
      tick(3);
      expSt = '{default: B_IDLE};
      cmd(4'h3, 2'd0, 1'b0);
      cmd(4'h3, 2'd1, 1'b0);
      chk(bankStates[1], B_ACTIVATING);
      tick(2);
      expSt[0] = B_ACTIVE;
      expSt[1] = B_ACTIVE;
      banks();
      b = 2'(2 + $unsigned($random(seed)) % 2);
      cmd(4'h2, b, 1'b0);
      banks();
      cmd(4'h5, 2'd0, 1'b0);
      tick(2);
      chk(dataStat.rdValid, 1'b0);
      tick(1);
      chk(dataStat.rdValid, 1'b1);
      chk(dataStat.rdBank, 2'd0);
      tick(6);
      cmd(4'h5, 2'd0, 1'b1);
      chk(bankStates[0], B_READ_AP);
      cmd(4'h5, 2'd1, 1'b0);
      chk(bankStates[0], B_PRECHARGING);
      tick(2);
      chk(bankStates[0], B_IDLE);
      cmd(4'h2, 2'd0, 1'b1);
      chk(globalState, G_PREALL);
      tick(2);
      expSt = '{default: B_IDLE};
      banks();
      chk(globalState, G_NORMAL);
      cmd(4'h1, 2'd0, 1'b0);
      cmd(4'h3, 2'd2, 1'b0);
      tick(4);
      chk(globalState, G_REFRESH);
      tick(1);
      chk(globalState, G_NORMAL);
      banks();
      cmd(4'h0, 2'd0, 1'b0);
      chk(globalState, G_MODE);
      tick(2);
      chk(globalState, G_NORMAL);
      cmd(4'h3, 2'd2, 1'b0);
      tick(2);
      cmd(4'h4, 2'd2, 1'b0);
      chk(dataStat.wrAccept, 1'b1);
      chk(dataStat.wrBank, 2'd2);
      cmd(4'h1, 2'd0, 1'b0);
      chk(cmdIgnored, 1'b1);
      chk(globalState, G_NORMAL);
      cmd(4'h3, 2'd3, 1'b0);
      cmd(4'h4, 2'd2, 1'b1);
      cmd(4'h5, 2'd3, 1'b0);
      chk(bankStates[2], B_RECOVER);
      chk(dataStat.wrAccept, 1'b0);
      tick(2);
      chk(bankStates[2], B_PRECHARGING);
      tick(2);
      chk(bankStates[2], B_IDLE);
      cmd(4'h6, 2'd3, 1'b0);
      chk(dataStat.rdValid, 1'b0);
      chk(bankStates[3], B_ACTIVE);
      cmd(4'h2, 2'd3, 1'b0);
      tick(3);
      cke = 1'b0;
      req = 7'h08;
      tick(1);
      req = 7'h38;
      chk(globalState, G_SELF);
      chk(cmdIgnored, 1'b0);
      tick(2);
      cke = 1'b1;
      tick(1);
      chk(globalState, G_EXIT);
      tick(6);
      chk(globalState, G_EXIT);
      tick(1);
      chk(globalState, G_NORMAL);
      cke = 1'b0;
      req = 7'h28;
      tick(1);
      req = 7'h38;
      cke = 1'b1;
      chk(cmdIgnored, 1'b1);
      tick(4);
      chk(dataStat.rdValid, 1'b0);
      conclude();
   end
endmodule : sdram_bank_interleave_test
